/* ext_bus_pkg.sv */
// Constants and types shared by the external memory bus sequencer
package ext_bus_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [7:0] CLOCK_CONTROL_IDX = 8'h8E;
  localparam logic [7:0] BUS_ACCESS_CONTROL_IDX = 8'h9D;
  localparam logic [7:0] TIMED_UNLOCK_IDX = 8'hC7;
  localparam logic [7:0] BUS_STATUS_IDX = 8'hF0;
  // Field positions
  localparam int STRETCH_LSB = 0;
  localparam int STRETCH_MSB = 2;
  localparam int PAGE_MODE_ENABLE_BIT = 7;
  localparam int PAGE_SELECT_HIGH_BIT = 6;
  localparam int PAGE_SELECT_LOW_BIT = 5;
  localparam int ALE_INTERNAL_BIT = 4;
  // Reset values
  localparam logic [7:0] CLOCK_CONTROL_RST = 8'h01;
  localparam logic [7:0] BUS_ACCESS_CONTROL_RST = 8'h00;
  // Timed-access keys
  localparam logic [7:0] UNLOCK_KEY_FIRST = 8'hAA;
  localparam logic [7:0] UNLOCK_KEY_SECOND = 8'h55;
  // Page select codes
  localparam logic [1:0] PAGE_SEL_SPLIT = 2'h3;
  localparam logic [1:0] PAGE_SEL_ONE = 2'h0;
  // Timing counts in system clocks
  localparam logic [5:0] BASIC_CYCLE_CLKS = 6'h04;
  localparam logic [5:0] STRETCH_CYCLE_CLKS = 6'h04;
  localparam logic [5:0] DATA_BASE_CLKS = 6'h08;
  localparam logic [5:0] INTERNAL_CYCLE_CLKS = 6'h01;

  typedef struct packed {
    logic code;
    logic internal;
    logic write;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic [5:0] ale;
    logic [5:0] setup;
    logic [5:0] strobe;
    logic [5:0] hold;
  } phase_len_t;

  typedef struct packed {
    logic ale;
    logic program_store_strobe_n;
    logic rd_n;
    logic wr_n;
    logic [7:0] p0_out;
    logic p0_oe;
    logic [7:0] p2_out;
    logic p2_oe;
  } bus_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ALE = 3'b001,
    ST_SETUP = 3'b010,
    ST_STROBE = 3'b011,
    ST_HOLD = 3'b100
  } bus_state_t;

  typedef enum logic [1:0] {
    UL_LOCKED = 2'b00,
    UL_HALF = 2'b01,
    UL_OPEN = 2'b10
  } unlock_state_t;
endpackage

/* ext_bus_seq.sv */
// External memory bus sequencer with its control registers
// Overview of operation
// - Non-page external fetch 4 clocks, internal 1
// - No ALE on internal fetch unless option
// - ALE on external code fetches except page hits
// - Program store strobe only on external fetches
// - Non-page basic data cycle is four clocks
// - Stretch from clock_control bits 2:0, writable anytime
// - Each stretch cycle is four clocks
// - Stretch 000: data move takes two cycles
// - Codes 1-3 add cycles; first adds setup/hold
// - Codes 4-7: 7-10 cycles, wider ALE/setup/hold/strobe
// - Strobe width 2, 4, then 4 per step
// - Stretch field resets to one
// - Page enable bit 7 selects page mode
// - Select 00/01/10: hit 1/2/4, miss double
// - Select 11: fetch 2/4, data always 4
// - Access control writable only after timed unlock
// - Miss when high address byte changes
// - Page hit: no ALE, low byte on port 2 (select 11: port 0)
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ns
module ext_bus_seq #(
  parameter int AV_ADDR_W = 10
) (
  input wire logic ref_clk, // System clock, 125 MHz
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic [AV_ADDR_W-1:0] avs_address, // Avalon byte address
  input wire logic avs_read, // Avalon read
  input wire logic avs_write, // Avalon write
  input wire logic [3:0] avs_byteenable, // Avalon byte enables
  input wire logic [31:0] avs_writedata, // Avalon write data
  output logic [31:0] avs_readdata, // Avalon read data
  output logic avs_waitrequest, // Avalon wait request
  input wire logic req_valid, // Core access request
  input wire ext_bus_pkg::mem_req_t req, // Access descriptor
  output logic req_ready, // Sequencer idle, request taken
  output logic done, // Access complete pulse
  output logic [7:0] rdata, // Read or fetch data
  output ext_bus_pkg::bus_pins_t pins, // Bus pin drive
  input wire logic [7:0] p0_in, // Port 0 pin level
  input wire logic [7:0] p2_in // Port 2 pin level
);
  if (AV_ADDR_W < 10) begin : g_addr_w_check
    $error("AV_ADDR_W must be at least 10");
  end

  function automatic logic [5:0] stretch_cycles(input logic [2:0] code);
    stretch_cycles = code[2] ? {3'h0, code} + 6'h03 : {3'h0, code};
  endfunction

  function automatic logic [5:0] strobe_width(input logic [2:0] code);
    strobe_width = (code == 3'h0) ? 6'h02 : {1'b0, code, 2'b00};
  endfunction

  // Phase lengths of one access, decided once at its start
  function automatic ext_bus_pkg::phase_len_t plan(
    input ext_bus_pkg::mem_req_t r, input logic pg_en, input logic [1:0] pg_sel,
    input logic miss, input logic [2:0] code, input logic ale_opt);
    ext_bus_pkg::phase_len_t l;
    logic [5:0] hit;
    l = '0;
    hit = 6'h01 << pg_sel;
    if (r.internal) begin
      if (ale_opt) l.ale = ext_bus_pkg::INTERNAL_CYCLE_CLKS;
      else l.strobe = ext_bus_pkg::INTERNAL_CYCLE_CLKS;
    end else if (!pg_en || (pg_sel == ext_bus_pkg::PAGE_SEL_SPLIT && !r.code)) begin
      if (r.code || pg_en) begin
        l.ale = 6'h01;
        l.strobe = ext_bus_pkg::BASIC_CYCLE_CLKS >> 1;
        l.hold = 6'h01;
      end else begin
        l.strobe = strobe_width(code);
        l.ale = code[2] ? 6'h06 : 6'h02;
        l.setup = (code == 3'h0) ? 6'h02 : (code[2] ? 6'h07 : 6'h03);
        l.hold = l.setup;
      end
    end else begin
      if (pg_sel == ext_bus_pkg::PAGE_SEL_SPLIT) hit = 6'h02;
      l.setup = hit >> 2;
      l.hold = (pg_sel == ext_bus_pkg::PAGE_SEL_SPLIT) ? 6'h01 : hit >> 2;
      l.strobe = hit - l.setup - l.hold;
      if (!r.code) l.strobe = l.strobe + (stretch_cycles(code) << 2);
      if (miss) l.ale = hit;
    end
    return l;
  endfunction

  // Next phase with a nonzero length, used at start and at each phase end
  function automatic ext_bus_pkg::bus_state_t next_phase(
    input ext_bus_pkg::bus_state_t from, input ext_bus_pkg::phase_len_t l);
    if (from == ext_bus_pkg::ST_IDLE && l.ale != 6'h00) next_phase = ext_bus_pkg::ST_ALE;
    else if ((from == ext_bus_pkg::ST_IDLE || from == ext_bus_pkg::ST_ALE) && l.setup != 6'h00)
      next_phase = ext_bus_pkg::ST_SETUP;
    else if (from != ext_bus_pkg::ST_STROBE && from != ext_bus_pkg::ST_HOLD && l.strobe != 6'h00)
      next_phase = ext_bus_pkg::ST_STROBE;
    else if (from != ext_bus_pkg::ST_HOLD && l.hold != 6'h00) next_phase = ext_bus_pkg::ST_HOLD;
    else next_phase = ext_bus_pkg::ST_IDLE;
  endfunction

  function automatic logic [5:0] len_of(
    input ext_bus_pkg::bus_state_t s, input ext_bus_pkg::phase_len_t l);
    unique case (s)
      ext_bus_pkg::ST_ALE: len_of = l.ale;
      ext_bus_pkg::ST_SETUP: len_of = l.setup;
      ext_bus_pkg::ST_STROBE: len_of = l.strobe;
      ext_bus_pkg::ST_HOLD: len_of = l.hold;
      default: len_of = 6'h01;
    endcase
  endfunction

  // Registers
  logic [7:0] clock_control_reg;
  logic [7:0] bus_access_control_reg;
  ext_bus_pkg::unlock_state_t unlock_reg;
  ext_bus_pkg::unlock_state_t unlock_next;
  logic waitreq_reg;
  logic [31:0] readdata_reg;
  // Sequencer state
  ext_bus_pkg::bus_state_t state_reg;
  ext_bus_pkg::bus_state_t state_next;
  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  ext_bus_pkg::phase_len_t len_reg;
  ext_bus_pkg::mem_req_t acc_reg;
  logic pg_en_reg;
  logic [1:0] pg_sel_reg;
  logic miss_reg;
  logic [2:0] stretch_reg;
  logic ale_opt_reg;
  logic [7:0] last_hi_reg;
  logic page_valid_reg;
  logic force_miss_reg;
  logic ready_reg;
  logic done_reg;
  logic [7:0] rdata_reg;
  ext_bus_pkg::bus_pins_t pins_reg;
  ext_bus_pkg::bus_pins_t pins_next;
  logic [7:0] p0_s1_reg;
  logic [7:0] p0_s2_reg;
  logic [7:0] p2_s1_reg;
  logic [7:0] p2_s2_reg;
  logic [1:0] cap_reg;

  // Register bus decode
  wire [7:0] reg_idx = avs_address[9:2];
  wire bus_req = avs_read || avs_write;
  wire wr_fire = avs_write && !waitreq_reg && avs_byteenable[0];
  wire [7:0] wr_byte = avs_writedata[7:0];
  wire ck_hit = reg_idx == ext_bus_pkg::CLOCK_CONTROL_IDX;
  wire ac_hit = reg_idx == ext_bus_pkg::BUS_ACCESS_CONTROL_IDX;
  wire ul_hit = reg_idx == ext_bus_pkg::TIMED_UNLOCK_IDX;
  wire st_hit = reg_idx == ext_bus_pkg::BUS_STATUS_IDX;
  wire ac_write = wr_fire && ac_hit && unlock_reg == ext_bus_pkg::UL_OPEN;
  wire [31:0] status_word = {16'h0000, last_hi_reg, 4'h0, unlock_reg == ext_bus_pkg::UL_OPEN,
    miss_reg, page_valid_reg, state_reg != ext_bus_pkg::ST_IDLE};
  wire [31:0] rd_value = ck_hit ? {24'h000000, clock_control_reg} :
    ac_hit ? {24'h000000, bus_access_control_reg} : st_hit ? status_word : 32'h00000000;

  // Any write other than the key sequence relocks the access control register
  always_comb begin
    unlock_next = ext_bus_pkg::UL_LOCKED;
    if (ul_hit && wr_byte == ext_bus_pkg::UNLOCK_KEY_FIRST) unlock_next = ext_bus_pkg::UL_HALF;
    else if (ul_hit && wr_byte == ext_bus_pkg::UNLOCK_KEY_SECOND && unlock_reg == ext_bus_pkg::UL_HALF)
      unlock_next = ext_bus_pkg::UL_OPEN;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      clock_control_reg <= ext_bus_pkg::CLOCK_CONTROL_RST;
      bus_access_control_reg <= ext_bus_pkg::BUS_ACCESS_CONTROL_RST;
      unlock_reg <= ext_bus_pkg::UL_LOCKED;
      waitreq_reg <= 1'b1;
      readdata_reg <= 32'h00000000;
    end else if (ce) begin
      waitreq_reg <= !(bus_req && waitreq_reg);
      if (bus_req && waitreq_reg) readdata_reg <= avs_read ? rd_value : 32'h00000000;
      if (wr_fire && ck_hit) clock_control_reg <= wr_byte;
      if (ac_write) bus_access_control_reg <= wr_byte;
      if (wr_fire) unlock_reg <= unlock_next;
    end
  end

  // Live settings; sampled only when an access starts
  wire live_pg_en = bus_access_control_reg[ext_bus_pkg::PAGE_MODE_ENABLE_BIT];
  wire [1:0] live_pg_sel = {bus_access_control_reg[ext_bus_pkg::PAGE_SELECT_HIGH_BIT],
    bus_access_control_reg[ext_bus_pkg::PAGE_SELECT_LOW_BIT]};
  wire live_ale_opt = bus_access_control_reg[ext_bus_pkg::ALE_INTERNAL_BIT];
  wire [2:0] live_stretch = clock_control_reg[ext_bus_pkg::STRETCH_MSB:ext_bus_pkg::STRETCH_LSB];
  wire fast_page = live_pg_sel == ext_bus_pkg::PAGE_SEL_ONE;
  wire live_miss = !page_valid_reg || req.addr[15:8] != last_hi_reg || force_miss_reg
    || (fast_page && !req.code);
  wire accept = req_valid && ready_reg;
  ext_bus_pkg::phase_len_t plan_now;
  assign plan_now = plan(req, live_pg_en, live_pg_sel, live_miss, live_stretch, live_ale_opt);
  wire phase_end = state_reg != ext_bus_pkg::ST_IDLE && cnt_reg == 6'h00;
  wire last_edge = phase_end && state_next == ext_bus_pkg::ST_IDLE;
  ext_bus_pkg::phase_len_t len_sel;
  assign len_sel = accept ? plan_now : len_reg;
  assign state_next = accept ? next_phase(ext_bus_pkg::ST_IDLE, plan_now) :
    phase_end ? next_phase(state_reg, len_reg) : state_reg;
  assign cnt_next = (accept || phase_end) ? len_of(state_next, len_sel) - 6'h01 : cnt_reg - 6'h01;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_reg <= ext_bus_pkg::ST_IDLE;
      cnt_reg <= 6'h00;
      len_reg <= '0;
      acc_reg <= '0;
      pg_en_reg <= 1'b0;
      pg_sel_reg <= 2'h0;
      miss_reg <= 1'b0;
      stretch_reg <= 3'h0;
      ale_opt_reg <= 1'b0;
      ready_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      ready_reg <= state_next == ext_bus_pkg::ST_IDLE && !accept;
      done_reg <= last_edge;
      if (accept) begin
        len_reg <= plan_now;
        acc_reg <= req;
        pg_en_reg <= live_pg_en;
        pg_sel_reg <= live_pg_sel;
        miss_reg <= live_miss;
        stretch_reg <= live_stretch;
        ale_opt_reg <= live_ale_opt;
      end
    end
  end

  // Page tracking; an access control write forces the next access to miss
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      last_hi_reg <= 8'h00;
      page_valid_reg <= 1'b0;
      force_miss_reg <= 1'b0;
    end else if (ce) begin
      if (ac_write) page_valid_reg <= 1'b0;
      else if (accept && !req.internal && live_pg_en && plan_now.ale != 6'h00) begin
        last_hi_reg <= req.addr[15:8];
        page_valid_reg <= 1'b1;
      end
      if (accept && !req.internal) force_miss_reg <= fast_page && !req.code;
    end
  end

  // Pin drive for the current phase
  wire busy_ext = state_reg != ext_bus_pkg::ST_IDLE && !acc_reg.internal;
  wire split_bus = pg_en_reg && pg_sel_reg == ext_bus_pkg::PAGE_SEL_SPLIT;
  wire in_ale = state_reg == ext_bus_pkg::ST_ALE;
  wire strobing = busy_ext && state_reg == ext_bus_pkg::ST_STROBE;
  wire drive_data = busy_ext && acc_reg.write && !acc_reg.code && !in_ale;
  always_comb begin
    pins_next.ale = in_ale;
    pins_next.program_store_strobe_n = !(strobing && acc_reg.code);
    pins_next.rd_n = !(strobing && !acc_reg.code && !acc_reg.write);
    pins_next.wr_n = !(strobing && !acc_reg.code && acc_reg.write);
    pins_next.p0_out = 8'h00;
    pins_next.p0_oe = 1'b0;
    pins_next.p2_out = 8'h00;
    pins_next.p2_oe = 1'b0;
    if (busy_ext && split_bus) begin
      pins_next.p0_out = acc_reg.addr[7:0];
      pins_next.p0_oe = 1'b1;
      pins_next.p2_out = in_ale ? acc_reg.addr[15:8] : acc_reg.wdata;
      pins_next.p2_oe = in_ale || drive_data;
    end else if (busy_ext && pg_en_reg) begin
      pins_next.p2_out = in_ale ? acc_reg.addr[15:8] : acc_reg.addr[7:0];
      pins_next.p2_oe = 1'b1;
      pins_next.p0_out = acc_reg.wdata;
      pins_next.p0_oe = drive_data;
    end else if (busy_ext) begin
      pins_next.p2_out = acc_reg.addr[15:8];
      pins_next.p2_oe = 1'b1;
      pins_next.p0_out = in_ale ? acc_reg.addr[7:0] : acc_reg.wdata;
      pins_next.p0_oe = in_ale || drive_data;
    end
  end

  // Pin inputs cross in through two flops, so read data lands after done only when the hold phase is under three clocks
  wire [7:0] bus_data_in = split_bus ? p2_s2_reg : p0_s2_reg;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pins_reg <= '{ale: 1'b0, program_store_strobe_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, p0_out: 8'h00,
        p0_oe: 1'b0, p2_out: 8'h00, p2_oe: 1'b0};
      p0_s1_reg <= 8'h00;
      p0_s2_reg <= 8'h00;
      p2_s1_reg <= 8'h00;
      p2_s2_reg <= 8'h00;
      cap_reg <= 2'b00;
      rdata_reg <= 8'h00;
    end else if (ce) begin
      pins_reg <= pins_next;
      p0_s1_reg <= p0_in;
      p0_s2_reg <= p0_s1_reg;
      p2_s1_reg <= p2_in;
      p2_s2_reg <= p2_s1_reg;
      cap_reg <= {cap_reg[0], !pins_reg.program_store_strobe_n || !pins_reg.rd_n};
      if (cap_reg[1]) rdata_reg <= bus_data_in;
    end
  end

  assign avs_readdata = readdata_reg;
  assign avs_waitrequest = waitreq_reg;
  assign req_ready = ready_reg;
  assign done = done_reg;
  assign rdata = rdata_reg;
  assign pins = pins_reg;

  // Helper counters for checks only
  logic [5:0] cyc_reg;
  logic [5:0] strb_reg;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cyc_reg <= 6'h00;
      strb_reg <= 6'h00;
    end else if (ce) begin
      cyc_reg <= accept ? 6'h01 : cyc_reg + 6'h01;
      strb_reg <= (!pins_reg.rd_n || !pins_reg.wr_n) ? strb_reg + 6'h01 : 6'h00;
    end
  end

  chk_fetch_four: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ce && last_edge && !pg_en_reg && acc_reg.code && !acc_reg.internal
      |-> cyc_reg == ext_bus_pkg::BASIC_CYCLE_CLKS)
    else $error("external fetch not four clocks");
  chk_internal_one: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ce && accept && req.internal |=> ##[0:8] (ce && done_reg) ##0 $past(cyc_reg) == 6'h01)
    else $error("internal fetch not one clock");
  chk_data_stretch: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ce && last_edge && !pg_en_reg && !acc_reg.code && !acc_reg.internal
      |-> cyc_reg == ext_bus_pkg::DATA_BASE_CLKS + (stretch_cycles(stretch_reg) << 2))
    else $error("data access length wrong for stretch code");
  chk_strobe_width: assert property (@(posedge ref_clk) disable iff (!rst_b)
    pins_reg.rd_n && pins_reg.wr_n && strb_reg != 6'h00 && !$past(pg_en_reg)
      |-> strb_reg == strobe_width($past(stretch_reg)))
    else $error("strobe width wrong");
  chk_stretch_reset: assert property (@(posedge ref_clk)
    $past(!rst_b) && rst_b |-> clock_control_reg[2:0] == 3'h1)
    else $error("stretch field not one after reset");
  chk_bus_access_control_locked: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $changed(bus_access_control_reg) |-> $past(unlock_reg) == ext_bus_pkg::UL_OPEN)
    else $error("access control written while locked");
  chk_program_store_strobe_internal: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !pins_reg.program_store_strobe_n |-> $past(busy_ext && acc_reg.code))
    else $error("program strobe outside external fetch");
  chk_ale_internal: assert property (@(posedge ref_clk) disable iff (!rst_b)
    in_ale && acc_reg.internal |-> ale_opt_reg)
    else $error("address strobe on internal fetch");
  chk_ale_fetch: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ce && accept && req.code && !req.internal && !live_pg_en |=> in_ale)
    else $error("no address strobe on external fetch");
  chk_hit_no_ale: assert property (@(posedge ref_clk) disable iff (!rst_b)
    busy_ext && pg_en_reg && !miss_reg && !(split_bus && !acc_reg.code) |-> !in_ale)
    else $error("address strobe on page hit");
  chk_page_len: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ce && last_edge && pg_en_reg && !split_bus && acc_reg.code
      |-> cyc_reg == ((6'h01 << pg_sel_reg) << miss_reg))
    else $error("page cycle length wrong");
  chk_split_data: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ce && last_edge && split_bus && !acc_reg.code && !acc_reg.internal |-> cyc_reg == 6'h04)
    else $error("split bus data access not four clocks");
  chk_settings_hold: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ce && busy_ext && !accept |=> $stable(stretch_reg) && $stable(pg_en_reg) && $stable(pg_sel_reg))
    else $error("settings changed mid access");
endmodule // ext_bus_seq

/* ext_mem_model.sv */
// Behavioural external memory with address latch facing the bus sequencer
`timescale 1ns/1ns
module ext_mem_model (
  input wire logic ref_clk, // System clock
  input wire ext_bus_pkg::bus_pins_t pins, // Sequencer pin drive
  output logic [7:0] p0_in, // Port 0 level
  output logic [7:0] p2_in // Port 2 level
);
  logic [15:0] addr_reg;
  logic [7:0] p0_last_reg;
  logic [7:0] p2_last_reg;
  wire logic mem_drive = !pins.program_store_strobe_n || !pins.rd_n;
  wire logic [7:0] mem_data = addr_reg[7:0] ^ addr_reg[15:8] ^ 8'h5A;
  // Released lines show the inverse of their last level, so stale data never reads back
  assign p0_in = pins.p0_oe ? pins.p0_out : (mem_drive ? mem_data : ~p0_last_reg);
  assign p2_in = pins.p2_oe ? pins.p2_out : ~p2_last_reg;
  always_ff @(posedge ref_clk) begin
    p0_last_reg <= p0_in;
    p2_last_reg <= p2_in;
    if (pins.ale) addr_reg <= {pins.p2_out, pins.p0_out};
  end
endmodule // ext_mem_model

/* tb.sv */
// Self-checking testbench for the external memory bus sequencer
`timescale 1ns/1ns
module tb;
  logic ref_clk, rst_b, ce, avs_read, avs_write, req_valid, avs_waitrequest, req_ready, done;
  logic [9:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0] rdata, p0_in, p2_in, wcap, w;
  logic [15:0] a;
  logic wr;
  ext_bus_pkg::mem_req_t req;
  ext_bus_pkg::bus_pins_t pins;
  int fails, cmp_count, len, n_ale, n_ps, n_strb;
  ext_bus_seq u_ext_bus_seq (.ref_clk(ref_clk), .rst_b(rst_b), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .done(done), .rdata(rdata), .pins(pins),
    .p0_in(p0_in), .p2_in(p2_in));
  ext_mem_model u_ext_mem_model (.ref_clk(ref_clk), .pins(pins), .p0_in(p0_in), .p2_in(p2_in));
  always #4 ref_clk = ~ref_clk;
  function automatic int scyc(int s); return s < 4 ? s : s + 3; endfunction
  function automatic int swid(int s); return s == 0 ? 2 : 4 * s; endfunction
  function automatic int hit_len(int s); return s == 3 ? 2 : 1 << s; endfunction
  function automatic logic [7:0] mdat(logic [15:0] x); return x[7:0] ^ x[15:8] ^ 8'h5A; endfunction
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task reg_acc(input logic wrt, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    @(posedge ref_clk);
    avs_address <= {idx, 2'b00};
    avs_write <= wrt;
    avs_read <= !wrt;
    avs_writedata <= {24'h000000, wd};
    n = 0;
    do begin @(posedge ref_clk); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) fails++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // Timed unlock must precede every access control write
  task ul_wr(input logic [7:0] v);
    reg_acc(1'b1, ext_bus_pkg::TIMED_UNLOCK_IDX, ext_bus_pkg::UNLOCK_KEY_FIRST);
    reg_acc(1'b1, ext_bus_pkg::TIMED_UNLOCK_IDX, ext_bus_pkg::UNLOCK_KEY_SECOND);
    reg_acc(1'b1, ext_bus_pkg::BUS_ACCESS_CONTROL_IDX, v);
  endtask
  task acc(input logic cd, input logic in, input logic wt, input logic [15:0] ad,
      input logic [7:0] wd);
    int n;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req <= '{cd, in, wt, ad, wd};
    n = 0;
    do begin @(posedge ref_clk); n++; end while (req_ready !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    req_valid <= 1'b0;
    // Pins first show the access one clock after the take edge
    @(posedge ref_clk);
    len = 0;
    n_ale = 0;
    n_ps = 0;
    n_strb = 0;
    do begin
      @(negedge ref_clk);
      len++;
      n_ale += (pins.ale === 1'b1);
      n_ps += (pins.program_store_strobe_n === 1'b0);
      n_strb += (pins.rd_n === 1'b0 || pins.wr_n === 1'b0);
      if (pins.wr_n === 1'b0) wcap = pins.p0_out;
    end while (done !== 1'b1 && len < 200);
    // Read data crosses two pin flops after the last strobe clock
    repeat (3) @(posedge ref_clk);
  endtask
  initial begin
    #(8 * 20000);
    fails++;
    results;
  end
  initial begin
    ref_clk = 0; rst_b = 0; ce = 1; avs_read = 0; avs_write = 0; req_valid = 0;
    avs_address = '0; avs_byteenable = 4'hF; avs_writedata = '0; req = '0;
    fails = 0; cmp_count = 0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    void'($urandom(32'h7fb31158));
    reg_acc(1'b0, ext_bus_pkg::CLOCK_CONTROL_IDX, 8'h00);
    chk("clock_control", 32'h01, rd);
    reg_acc(1'b0, ext_bus_pkg::BUS_ACCESS_CONTROL_IDX, 8'h00);
    chk("bus_access_control", 32'h00, rd);
    reg_acc(1'b0, 8'h10, 8'h00);
    chk("unmapped", 32'h00, rd);
    reg_acc(1'b1, ext_bus_pkg::BUS_ACCESS_CONTROL_IDX, 8'h80);
    reg_acc(1'b0, ext_bus_pkg::BUS_ACCESS_CONTROL_IDX, 8'h00);
    chk("locked write", 32'h00, rd);
    $display("test registers done");
    for (int opt = 0; opt < 2; opt++) begin
      a = 16'($urandom);
      acc(1'b1, 1'b1, 1'b0, a, 8'h00);
      chk("internal len", 32'd1, 32'(len));
      chk("internal ale", 32'(opt), 32'(n_ale));
      chk("internal program_store_strobe", 32'd0, 32'(n_ps));
      acc(1'b1, 1'b0, 1'b0, a, 8'h00);
      chk("fetch len", 32'd4, 32'(len));
      chk("fetch ale", 32'd1, 32'(n_ale > 0));
      chk("fetch program_store_strobe", 32'd2, 32'(n_ps));
      chk("fetch data", {24'h0, mdat(a)}, {24'h0, rdata});
      ul_wr(8'h10);
    end
    reg_acc(1'b1, ext_bus_pkg::BUS_ACCESS_CONTROL_IDX, 8'h00);
    reg_acc(1'b0, ext_bus_pkg::BUS_ACCESS_CONTROL_IDX, 8'h00);
    chk("relocked", 32'h10, rd);
    ul_wr(8'h00);
    $display("test fetch done");
    for (int s = 0; s < 8; s++) begin
      reg_acc(1'b1, ext_bus_pkg::CLOCK_CONTROL_IDX, 8'(s));
      reg_acc(1'b0, ext_bus_pkg::CLOCK_CONTROL_IDX, 8'h00);
      chk("stretch field", 32'(s), rd);
      a = 16'($urandom);
      w = 8'($urandom);
      wr = (s == 0) ? 1'b0 : (s == 7) ? 1'b1 : 1'($urandom);
      acc(1'b0, 1'b0, wr, a, w);
      chk("data len", 32'(8 + 4 * scyc(s)), 32'(len));
      chk("strobe width", 32'(swid(s)), 32'(n_strb));
      if (wr) chk("write data", {24'h0, w}, {24'h0, wcap});
      else chk("read data", {24'h0, mdat(a)}, {24'h0, rdata});
    end
    reg_acc(1'b1, ext_bus_pkg::CLOCK_CONTROL_IDX, 8'h01);
    fork
      acc(1'b0, 1'b0, 1'b0, a, 8'h00);
      begin
        repeat (3) @(posedge ref_clk);
        reg_acc(1'b1, ext_bus_pkg::CLOCK_CONTROL_IDX, 8'h03);
      end
    join
    chk("len during change", 32'd12, 32'(len));
    acc(1'b0, 1'b0, 1'b0, a, 8'h00);
    chk("len after change", 32'd20, 32'(len));
    reg_acc(1'b1, ext_bus_pkg::CLOCK_CONTROL_IDX, 8'h00);
    $display("test stretch done");
    // Five frozen clocks in mid fetch stretch it by exactly five
    fork
      acc(1'b1, 1'b0, 1'b0, a, 8'h00);
      begin
        repeat (3) @(posedge ref_clk);
        ce <= 1'b0;
        repeat (5) @(posedge ref_clk);
        ce <= 1'b1;
      end
    join
    chk("len with ce low", 32'd9, 32'(len));
    chk("fetch data ce", {24'h0, mdat(a)}, {24'h0, rdata});
    $display("test clock enable done");
    for (int sel = 0; sel < 4; sel++) begin
      ul_wr(8'h80 | 8'(sel << 5));
      a = 16'($urandom);
      acc(1'b1, 1'b0, 1'b0, a, 8'h00);
      chk("page miss len", 32'(2 * hit_len(sel)), 32'(len));
      acc(1'b1, 1'b0, 1'b0, {a[15:8], ~a[7:0]}, 8'h00);
      chk("page hit len", 32'(hit_len(sel)), 32'(len));
      chk("page hit ale", 32'd0, 32'(n_ale));
      if (sel == 3) begin
        acc(1'b0, 1'b0, 1'b0, a, 8'h00);
        chk("split data len", 32'd4, 32'(len));
      end
    end
    ul_wr(8'h00);
    acc(1'b1, 1'b0, 1'b0, a, 8'h00);
    chk("non-page again", 32'd4, 32'(len));
    $display("test page done");
    results;
  end
endmodule // tb
